// >>> core/ssw_pkg.sv
// Shared constants and carrier types for the supply supervisor and watchdog.
// Assumes a single 10 MHz core clock; comparator results arrive as digital levels.
package ssw_pkg;

    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICK_MS = 1;
    localparam int RESET_PULSE_MS = 50;
    localparam int RESET_PULSE_LONG_MS = 200;
    localparam int WDOG_TIMEOUT_MS = 1600;

    localparam int CNT_W = 11;
    localparam int DIV_W = 16;
    localparam logic [CNT_W-1:0] RESET_PULSE_TICKS = CNT_W'(RESET_PULSE_MS / TICK_MS);
    localparam logic [CNT_W-1:0] RESET_LONG_TICKS = CNT_W'(RESET_PULSE_LONG_MS / TICK_MS);
    localparam logic [CNT_W-1:0] WDOG_TIMEOUT_TICKS = CNT_W'(WDOG_TIMEOUT_MS / TICK_MS);

    localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
    localparam logic [DIV_W-1:0] DIV_ZERO = 16'h0000;
    localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;

    // Asynchronous pin and comparator levels, synchronised as one group.
    typedef struct packed {
        logic supply_low;
        logic power_fail_sense_in;
        logic vcc_above_batt;
        logic batt_near_vcc;
        logic kick_floating;
        logic chip_enable_in_n;
        logic watchdog_kick_input;
        logic timing_source_in;
        logic timing_source_select;
    } ssw_pins_s;

    typedef struct packed {
        logic proc_reset_n;
        logic proc_reset;
        logic chip_enable_out_n;
        logic power_fail_warn_n;
        logic watchdog_expired_n;
        logic on_backup_indicator;
        logic supply_from_backup;
    } ssw_outs_s;

    localparam ssw_pins_s PINS_RESET = 9'h000;
    localparam ssw_outs_s OUTS_RESET = 7'h3C;

endpackage : ssw_pkg

// >>> core/ssw_top.sv
// Supply supervisor: processor reset, chip-enable gating, power-fail warning,
// battery switchover indication and watchdog; reset pulses and watchdog timeout are timed from a selectable tick.
// Assumes comparators outside deliver clean digital levels asynchronous to core_clk.
//
// Behaviour
// [R1] Hold processor reset low while the supply is below trip level.
// [R2] After supply recovers keep reset low 50 ms, or 200 ms long variant.
// [R3] Provide an active-high reset output, always the inverse of reset.
// [R4] With supply good, gated chip enable follows the chip enable input.
// [R5] With supply low, gated chip enable is forced high.
// [R6] Processor must toggle the kick input at least every 1.6 s.
// [R7] Missing kick for 1.6 s produces a 50 ms or 200 ms reset pulse.
// [R8] Without kicks the watchdog reset pulse repeats every 1.6 s; pulses start 1.65 s apart, 1.8 s in the long variant.
// [R9] Watchdog expired output goes low when the timeout elapses.
// [R10] Expired output stays low until the next kick transition, then high.
// [R11] A floating kick input disables the watchdog entirely.
// [R12] Power-fail warning is low while sense input is below 1.3 V.
// [R13] Backed-up output is fed from main supply, else from battery.
// [R14] Backup indicator low while main supply exceeds battery, else high.
// [R15] Battery pin within 50 mV of supply generates a reset pulse.
// [R16] Pulse width and timeout are adjustable by external timing source.
// [R17] Select high times everything from the internal oscillator.
// [R18] Select low times from the external capacitor or clock source.
// [R19] Watchdog count restarts on every kick edge and at reset pulse end.
// [R20] Intervals are counted in periods of the selected timing tick.
`timescale 1ns/1ps

module ssw_top #(
    parameter int TICK_CYCLES = ssw_pkg::TICK_CYCLES,
    parameter bit LONG_PULSE = 1'b0
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire ssw_pkg::ssw_pins_s pins,
    output ssw_pkg::ssw_outs_s outs
);
    import ssw_pkg::*;

    logic rst_s1_q;
    logic rst_n_i;
    ssw_pins_s pins_s1_q;
    ssw_pins_s pins_s2_q;
    ssw_pins_s pins_s3_q;
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;
    logic [CNT_W-1:0] rst_cnt_q;
    logic [CNT_W-1:0] rst_cnt_d;
    logic [CNT_W-1:0] wd_cnt_q;
    logic [CNT_W-1:0] wd_cnt_d;
    logic rst_act_q;
    logic rst_act_d;
    logic expired_q;
    logic expired_d;
    ssw_outs_s outs_q;
    ssw_outs_s outs_d;
    logic tick;
    logic kick_edge;
    logic batt_rise;
    logic wd_fire;
    logic reset_end;
    logic [CNT_W-1:0] pulse_len;

    // Reset release is synchronised; assertion stays asynchronous.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_q <= 1'b0;
            rst_n_i <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_i <= rst_s1_q;
        end
    end

    // Stage one feeds stage two only; edges are taken between stages two and three.
    always_ff @(posedge core_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pins_s1_q <= PINS_RESET;
            pins_s2_q <= PINS_RESET;
            pins_s3_q <= PINS_RESET;
        end else begin
            pins_s1_q <= pins;
            pins_s2_q <= pins_s1_q;
            pins_s3_q <= pins_s2_q;
        end
    end

    always_comb begin
        div_d = div_q + DIV_ONE;
        if (div_q >= DIV_W'(TICK_CYCLES - 1)) begin
            div_d = DIV_ZERO;
        end
        // Internal oscillator or external source edges, per select.
        if (pins_s2_q.timing_source_select) begin // [R17] [R16]
            tick = (div_q >= DIV_W'(TICK_CYCLES - 1));
        end else begin // [R18]
            tick = pins_s2_q.timing_source_in & ~pins_s3_q.timing_source_in;
        end
        kick_edge = pins_s2_q.watchdog_kick_input ^ pins_s3_q.watchdog_kick_input;
        batt_rise = pins_s2_q.batt_near_vcc & ~pins_s3_q.batt_near_vcc;
        pulse_len = LONG_PULSE ? RESET_LONG_TICKS : RESET_PULSE_TICKS;
        // The watchdog does not run during a reset pulse, so repeats are spaced by the timeout.
        wd_fire = tick & ~pins_s2_q.kick_floating & ~rst_act_q &
                  (wd_cnt_q == WDOG_TIMEOUT_TICKS - CNT_ONE); // [R7] [R8] [R20]

        rst_act_d = rst_act_q;
        rst_cnt_d = rst_cnt_q;
        if (pins_s2_q.supply_low) begin // [R1]
            rst_act_d = 1'b1;
            rst_cnt_d = CNT_ZERO;
        end else if (wd_fire || batt_rise) begin // [R7] [R15]
            rst_act_d = 1'b1;
            rst_cnt_d = CNT_ZERO;
        end else if (rst_act_q && tick) begin // [R2] [R20]
            if (rst_cnt_q == pulse_len - CNT_ONE) begin
                rst_act_d = 1'b0;
                rst_cnt_d = CNT_ZERO;
            end else begin
                rst_cnt_d = rst_cnt_q + CNT_ONE;
            end
        end
        reset_end = rst_act_q & ~rst_act_d;

        wd_cnt_d = wd_cnt_q;
        if (pins_s2_q.kick_floating || kick_edge || reset_end || rst_act_q || wd_fire) begin
            wd_cnt_d = CNT_ZERO; // [R19] [R11]
        end else if (tick) begin
            wd_cnt_d = wd_cnt_q + CNT_ONE;
        end

        expired_d = expired_q;
        if (pins_s2_q.kick_floating || kick_edge) begin // [R10] [R11]
            expired_d = 1'b0;
        end else if (wd_fire) begin // [R9]
            expired_d = 1'b1;
        end

        outs_d.proc_reset_n = ~rst_act_d;
        outs_d.proc_reset = rst_act_d; // [R3]
        outs_d.chip_enable_out_n = pins_s2_q.supply_low | pins_s2_q.chip_enable_in_n; // [R4] [R5]
        outs_d.power_fail_warn_n = ~pins_s2_q.power_fail_sense_in; // [R12]
        outs_d.watchdog_expired_n = ~expired_d;
        outs_d.on_backup_indicator = ~pins_s2_q.vcc_above_batt; // [R14]
        outs_d.supply_from_backup = ~pins_s2_q.vcc_above_batt; // [R13]
    end

    // Power-up starts with reset active so the first pulse is timed out normally.
    always_ff @(posedge core_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= DIV_ZERO;
            rst_cnt_q <= CNT_ZERO;
            wd_cnt_q <= CNT_ZERO;
            rst_act_q <= 1'b1;
            expired_q <= 1'b0;
            outs_q <= OUTS_RESET;
        end else begin
            div_q <= div_d;
            rst_cnt_q <= rst_cnt_d;
            wd_cnt_q <= wd_cnt_d;
            rst_act_q <= rst_act_d;
            expired_q <= expired_d;
            outs_q <= outs_d;
        end
    end

    assign outs = outs_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n_i);

    a_reset_held_low: assert property (pins_s2_q.supply_low |=> !outs_q.proc_reset_n) // [R1]
        else $error("Reset released while supply low.");
    a_reset_pulse_len: assert property ( // [R2]
        (!pins_s2_q.supply_low && rst_act_q && tick && !wd_fire && !batt_rise &&
         rst_cnt_q == pulse_len - CNT_ONE) |=> outs_q.proc_reset_n)
        else $error("Reset not released at end of pulse.");
    a_reset_inverse: assert property (outs_q.proc_reset == !outs_q.proc_reset_n) // [R3]
        else $error("Active-high reset not inverse.");
    a_ce_follow: assert property ( // [R4]
        !pins_s2_q.supply_low |=> outs_q.chip_enable_out_n == $past(pins_s2_q.chip_enable_in_n))
        else $error("Chip enable does not follow input.");
    a_ce_forced: assert property (pins_s2_q.supply_low |=> outs_q.chip_enable_out_n) // [R5]
        else $error("Chip enable not forced high.");
    a_wd_fire_pulse: assert property ( // [R7]
        (wd_fire && !pins_s2_q.supply_low) |=> !outs_q.proc_reset_n && rst_cnt_q == CNT_ZERO)
        else $error("Watchdog timeout gave no reset pulse.");
    // A kick in the fire cycle clears the flag, so only an unserviced fire must set it.
    a_wdo_set: assert property ((wd_fire && !kick_edge) |=> !outs_q.watchdog_expired_n) // [R9]
        else $error("Expired output not driven low.");
    a_wdo_hold: assert property ( // [R10]
        (!outs_q.watchdog_expired_n && !kick_edge && !pins_s2_q.kick_floating)
        |=> !outs_q.watchdog_expired_n)
        else $error("Expired output released without kick.");
    a_wdo_clear: assert property (kick_edge |=> outs_q.watchdog_expired_n) // [R10]
        else $error("Expired output not cleared by kick.");
    a_wd_floating: assert property ( // [R11]
        pins_s2_q.kick_floating |-> !wd_fire ##1 outs_q.watchdog_expired_n)
        else $error("Floating kick still active.");
    a_pfail_warn: assert property ( // [R12]
        1'b1 |=> outs_q.power_fail_warn_n == !$past(pins_s2_q.power_fail_sense_in))
        else $error("Power-fail warning wrong.");
    a_backup_ind: assert property ( // [R13] [R14]
        1'b1 |=> outs_q.on_backup_indicator == !$past(pins_s2_q.vcc_above_batt) &&
                 outs_q.supply_from_backup == outs_q.on_backup_indicator)
        else $error("Backup indication wrong.");
    a_batt_pulse: assert property (batt_rise |=> !outs_q.proc_reset_n) // [R15]
        else $error("Battery near supply gave no reset.");
    a_wd_restart: assert property (kick_edge |=> wd_cnt_q == CNT_ZERO) // [R19]
        else $error("Watchdog count not restarted.");
    // A stopped timing source stalls a reset pulse; it never ends between ticks.
    a_reset_no_early: assert property ((rst_act_q && !tick) |=> !outs_q.proc_reset_n) // [R20]
        else $error("Reset released without a timing tick.");
    a_wd_float_hold: assert property (pins_s2_q.kick_floating |=> wd_cnt_q == CNT_ZERO) // [R11]
        else $error("Watchdog counted while kick floating.");

    c_wd_expire: cover property (wd_fire);
    c_batt_pulse: cover property (batt_rise && !pins_s2_q.supply_low);
    c_ext_tick: cover property (!pins_s2_q.timing_source_select && tick);
    c_reset_end: cover property (reset_end);
    c_wdo_clear: cover property (kick_edge && !outs_q.watchdog_expired_n);

endmodule : ssw_top

// >>> dv/ssw_cpu_model.sv
// Processor and memory model on the far side of the supervisor.
// Assumes the bench hands it the supervisor clock and a chip-enable request.
`timescale 1ns/1ps
module ssw_cpu_model #(
    parameter int KICK_CYCLES = 1000
) (
    input wire logic core_clk,
    input wire logic kick_en,
    input wire logic ce_req,
    output logic kick,
    output logic ce_in_n
);
    int cnt = 0;
    initial kick = 1'b0;
    // The kick period sits far inside the timeout, so healthy code never trips it.
    always @(posedge core_clk) begin
        cnt <= (cnt >= KICK_CYCLES - 1) ? 0 : cnt + 1;
        if (kick_en && cnt == 0) begin
            kick <= #1 ~kick;
        end
    end
    assign ce_in_n = ~ce_req;
endmodule : ssw_cpu_model

// >>> dv/ssw_top_tb_top.sv
// Self-checking bench for the supply supervisor and watchdog.
// Assumes ssw_pkg and ssw_top are compiled first; one tick is shortened to 4 clocks.
`timescale 1ns/1ps
module ssw_top_tb_top;
    import ssw_pkg::*;
    localparam int TC = 4;
    localparam int PW = 50 * TC;
    localparam int TO = 1600 * TC;
    localparam int RN = 6;
    localparam int CE = 4;
    localparam int WD = 2;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic sl = 1'b0;
    logic pf = 1'b0;
    logic vab = 1'b1;
    logic bn = 1'b0;
    logic fl = 1'b0;
    logic tsi = 1'b0;
    logic tss = 1'b1;
    logic kick_en = 1'b1;
    logic ce_req = 1'b0;
    logic kick;
    logic ce_n;
    ssw_pins_s pins;
    ssw_outs_s outs;
    logic [6:0] ov;
    ssw_outs_s outs_long;
    logic [6:0] ol;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    assign pins = {sl, pf, vab, bn, fl, ce_n, kick, tsi, tss};
    assign ov = outs;
    assign ol = outs_long;
    ssw_top #(.TICK_CYCLES(TC), .LONG_PULSE(1'b0)) ssw_top_inst (
        .core_clk(core_clk), .reset_n(reset_n), .pins(pins), .outs(outs));
    // Second copy built as the long-pulse variant; it shares every pin with the first.
    ssw_top #(.TICK_CYCLES(TC), .LONG_PULSE(1'b1)) ssw_top_long_inst (
        .core_clk(core_clk), .reset_n(reset_n), .pins(pins), .outs(outs_long));
    ssw_cpu_model ssw_cpu_model_inst (.core_clk(core_clk), .kick_en(kick_en),
        .ce_req(ce_req), .kick(kick), .ce_in_n(ce_n));
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    task complete_run;
        if (n_fail == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    // A hang is cut short well past the expected length of the run.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            complete_run();
        end
    end
    task chk(input logic seen, input logic exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t output seen %b expected %b", $time, seen, exp);
        end
    endtask : chk
    task wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wt
    task wait_for(input int b, input logic v, input int lim);
        int k;
        k = 0;
        while (ov[b] !== v && k < lim) begin
            wt(1);
            k++;
        end
        chk(ov[b], v);
    endtask : wait_for
    task tick(input int n);
        repeat (n) begin
            tsi = 1'b1;
            wt(2);
            tsi = 1'b0;
            wt(2);
        end
    endtask : tick
    task t_supply;
        sl = 1'b1;
        ce_req = 1'b1;
        wt(4);
        chk(ov[RN], 1'b0);
        chk(ov[5], 1'b1);
        chk(ov[CE], 1'b1);
        wt(300);
        chk(ov[RN], 1'b0);
        sl = 1'b0;
        wt(PW - 10);
        chk(ov[RN], 1'b0);
        wait_for(RN, 1'b1, 30);
        chk(ov[5], 1'b0);
        chk(ov[CE], 1'b0);
        ce_req = 1'b0;
        wt(4);
        chk(ov[CE], 1'b1);
        chk(ol[RN], 1'b0);
        wt(3 * PW - 20);
        chk(ol[RN], 1'b0);
        for (int k = 0; k < 40 && ol[RN] !== 1'b1; k++) begin
            wt(1);
        end
        chk(ol[RN], 1'b1);
    endtask : t_supply
    task t_levels;
        for (int v = 1; v >= 0; v--) begin
            pf = v[0];
            vab = ~v[0];
            wt(4);
            chk(ov[3], ~v[0]);
            chk(ov[1], v[0]);
            chk(ov[0], v[0]);
        end
    endtask : t_levels
    task t_watchdog;
        @(kick);
        wt(1);
        kick_en = 1'b0;
        wt(TO - 40);
        chk(ov[WD], 1'b1);
        wait_for(WD, 1'b0, 80);
        chk(ov[RN], 1'b0);
        wt(PW - 20);
        chk(ov[RN], 1'b0);
        wait_for(RN, 1'b1, 40);
        chk(ov[WD], 1'b0);
        wt(TO - 40);
        chk(ov[RN], 1'b1);
        wait_for(RN, 1'b0, 80);
        kick_en = 1'b1;
        wait_for(WD, 1'b1, 1100);
        wait_for(RN, 1'b1, PW + 20);
    endtask : t_watchdog
    task t_float;
        logic bad;
        bad = 1'b0;
        fl = 1'b1;
        kick_en = 1'b0;
        repeat (TO + 200) begin
            wt(1);
            bad = bad | ~ov[RN] | ~ov[WD];
        end
        chk(bad, 1'b0);
        kick_en = 1'b1;
        wt(4);
        fl = 1'b0;
    endtask : t_float
    // With the external source stopped, a started pulse must not end on its own.
    task t_ext;
        tss = 1'b0;
        bn = 1'b1;
        wt(6);
        chk(ov[RN], 1'b0);
        wt(400);
        chk(ov[RN], 1'b0);
        tick(45);
        chk(ov[RN], 1'b0);
        tick(10);
        chk(ov[RN], 1'b1);
        tss = 1'b1;
        bn = 1'b0;
        wt(4);
    endtask : t_ext
    initial begin
        wt(2);
        reset_n = 1'b1;
        wt(PW - 20);
        chk(ov[RN], 1'b0);
        wait_for(RN, 1'b1, 60);
        t_supply();
        t_levels();
        t_watchdog();
        t_float();
        t_ext();
        complete_run();
    end
endmodule : ssw_top_tb_top
